// ### rtl/spme_host.sv
// Purpose: Host end that walks the vendor table and decodes it
// Assumes: Register port strobes one cycle long, never both at once
// Notes:   A fresh walk starts on a write of the start bit while idle; writes during a walk start nothing, but a start-bit write still clears the refusal flag
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module spme_host (
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    spme_if.host             tbl,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out
);
    // ----------------------------------------------------------------
    // Walk state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SPME_IDLE = 2'b00,
        SPME_REQ  = 2'b01,
        SPME_WAIT = 2'b10
    } spme_state_e;

    spme_state_e state_reg;
    logic [5:0]  idx_reg;
    logic [7:0]  buf_reg [spme_pkg::TBL_BYTES];
    logic        done_reg;
    logic        refused_reg;
    logic        twr_reg;
    logic [11:0] twr_addr_reg;
    logic [7:0]  twr_data_reg;
    logic        start;
    logic        last;

    assign start = wr_in && addr_in == spme_pkg::REG_CTRL && wdata_in[0];
    assign last  = idx_reg == 6'(spme_pkg::TBL_BYTES - 1);

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_reg <= SPME_IDLE;
            idx_reg   <= 6'h00;
            done_reg  <= 1'b0;
        end else if (ce_in) begin
            unique case (state_reg)
                SPME_IDLE: begin
                    if (start) begin
                        state_reg <= SPME_REQ;
                        idx_reg   <= 6'h00;
                        done_reg  <= 1'b0;
                    end
                end
                SPME_REQ: begin
                    state_reg <= SPME_WAIT;
                end
                SPME_WAIT: begin
                    idx_reg   <= idx_reg + 6'h01;
                    state_reg <= last ? SPME_IDLE : SPME_REQ;
                    done_reg  <= last;
                end
                default: begin
                    state_reg <= SPME_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (ce_in && state_reg == SPME_WAIT) begin
            buf_reg[idx_reg] <= tbl.tbl_rdata;
        end
    end

    // Write probe; refusal sticks until next start, set wins
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            twr_reg      <= 1'b0;
            twr_addr_reg <= 12'h000;
            twr_data_reg <= 8'h00;
            refused_reg  <= 1'b0;
        end else if (ce_in) begin
            twr_reg <= wr_in && addr_in == spme_pkg::REG_TWR && state_reg == SPME_IDLE;
            if (wr_in && addr_in == spme_pkg::REG_TWR) begin
                twr_addr_reg <= wdata_in[19:8];
                twr_data_reg <= wdata_in[7:0];
            end
            if (tbl.tbl_wr_refused) begin
                refused_reg <= 1'b1;
            end else if (start) begin
                refused_reg <= 1'b0;
            end
        end
    end

    assign tbl.tbl_rd    = ce_in && state_reg == SPME_REQ;
    assign tbl.tbl_addr  = tbl.tbl_wr ? twr_addr_reg :
                           spme_pkg::SEC_BASE + 12'(idx_reg);
    assign tbl.tbl_wr    = ce_in && twr_reg;
    assign tbl.tbl_wdata = twr_data_reg;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic [7:0]  m_val;
    logic [31:0] sec_word [spme_pkg::SEC_COUNT];
    logic [47:0] eui48;
    logic [63:0] eui64;
    logic [63:0] eui64x;
    logic        e48_ok;
    logic        e64_ok;
    logic        rsv_err;

    // m is the 64K count byte
    assign m_val = buf_reg[9];

    function automatic logic [9:0] bit_of(input logic [7:0] c, input logic [7:0] m);
        logic [10:0] sum;
        sum    = (11'h001 << m[3:0]) + 11'h001 + {{3{c[7]}}, c};
        bit_of = (c == 8'h00) ? 10'h000 : sum[9:0];
    endfunction

    always_comb begin
        for (int s = 0; s < spme_pkg::SEC_COUNT; s++) begin
            logic [7:0] ty;
            logic [7:0] n;
            logic [8:0] cnt;
            ty  = buf_reg[4*s];
            n   = buf_reg[4*s+1];
            cnt = 9'h001 << n[3:0];
            if (ty == spme_pkg::TYPE_64K) begin
                cnt = cnt - 9'h002;
            end
            sec_word[s] = {ty[3:0], cnt[7:0], bit_of(buf_reg[4*s+3], m_val),
                           bit_of(buf_reg[4*s+2], m_val)};
        end
    end

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            eui48[8*i +: 8] = buf_reg[21+i];
        end
        for (int i = 0; i < 8; i++) begin
            eui64[8*i +: 8] = buf_reg[28+i];
        end
    end

    assign e48_ok  = buf_reg[20] == spme_pkg::EUI48_SET;
    assign e64_ok  = buf_reg[27] == spme_pkg::EUI64_SET;
    assign rsv_err = e64_ok && (eui64[39:24] == spme_pkg::RSV_ENCAP ||
                                eui64[39:24] == spme_pkg::RSV_OTHER);
    assign eui64x  = {eui48[47:24], spme_pkg::RSV_ENCAP, eui48[23:0]};

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (ce_in && rd_in) begin
            rdata_out <= 32'h0000_0000;
            if (addr_in >= spme_pkg::REG_SEC0 &&
                addr_in < spme_pkg::REG_SEC0 + 8'(spme_pkg::SEC_COUNT)) begin
                rdata_out <= done_reg ? sec_word[3'(addr_in - spme_pkg::REG_SEC0)]
                                      : 32'h0000_0000;
            end else begin
                unique case (addr_in)
                    spme_pkg::REG_STAT: begin
                        rdata_out[spme_pkg::ST_BUSY]      <= state_reg != SPME_IDLE;
                        rdata_out[spme_pkg::ST_DONE]      <= done_reg;
                        rdata_out[spme_pkg::ST_E48_OK]    <= done_reg && e48_ok;
                        rdata_out[spme_pkg::ST_E64_OK]    <= done_reg && e64_ok;
                        rdata_out[spme_pkg::ST_RSV_ERR]   <= done_reg && rsv_err;
                        rdata_out[spme_pkg::ST_WR_REFUSE] <= refused_reg;
                    end
                    spme_pkg::REG_E48_LO:  rdata_out <= done_reg ? eui48[31:0] : '0;
                    spme_pkg::REG_E48_HI:  rdata_out <= done_reg ? {16'h0000, eui48[47:32]} : '0;
                    spme_pkg::REG_E64_LO:  rdata_out <= done_reg ? eui64[31:0] : '0;
                    spme_pkg::REG_E64_HI:  rdata_out <= done_reg ? eui64[63:32] : '0;
                    spme_pkg::REG_E64X_LO: rdata_out <= done_reg ? eui64x[31:0] : '0;
                    spme_pkg::REG_E64X_HI: rdata_out <= done_reg ? eui64x[63:32] : '0;
                    default:               rdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// ### rtl/spme_pkg.sv
// Purpose: Shared constants for the parameter table reader and server
// Assumes: Byte-wide table port, 12-bit table addresses
// Notes:   Adders are 8-bit two's complement values
package spme_pkg;
    // ----------------------------------------------------------------
    // Table layout
    // ----------------------------------------------------------------
    localparam int          M_DEFAULT    = 5;
    localparam int          TBL_AW       = 12;
    localparam int          SEC_COUNT    = 5;
    localparam logic [11:0] SEC_BASE     = 12'h24c;
    localparam logic [11:0] EUI48_FLAG   = 12'h260;
    localparam logic [11:0] EUI48_LO     = 12'h261;
    localparam logic [11:0] EUI48_HI     = 12'h266;
    localparam logic [11:0] EUI64_FLAG   = 12'h267;
    localparam logic [11:0] EUI64_LO     = 12'h268;
    localparam logic [11:0] EUI64_HI     = 12'h26f;
    localparam int          TBL_BYTES    = 36;
    // ----------------------------------------------------------------
    // Section contents
    // ----------------------------------------------------------------
    localparam logic [7:0]  TYPE_8K      = 8'h02;
    localparam logic [7:0]  TYPE_32K     = 8'h03;
    localparam logic [7:0]  TYPE_64K     = 8'h04;
    localparam logic [7:0]  N_8K         = 8'h02;
    localparam logic [7:0]  N_32K        = 8'h00;
    localparam logic [7:0]  ADD_B8_FIRST = 8'hff;
    localparam logic [7:0]  ADD_B8_LAST  = 8'h04;
    localparam logic [7:0]  ADD_L32      = 8'hfd;
    localparam logic [7:0]  ADD_64_FIRST = 8'h00;
    localparam logic [7:0]  ADD_64_LAST  = 8'hfc;
    localparam logic [7:0]  ADD_U32      = 8'hfe;
    localparam logic [7:0]  ADD_T8_FIRST = 8'h07;
    localparam logic [7:0]  ADD_T8_LAST  = 8'h0e;
    localparam int          SH_8K        = 13;
    localparam int          SH_32K       = 15;
    localparam int          SH_64K       = 16;
    // ----------------------------------------------------------------
    // Identifier flags
    // ----------------------------------------------------------------
    localparam logic [7:0]  EUI48_SET    = 8'h30;
    localparam logic [7:0]  EUI64_SET    = 8'h40;
    localparam logic [7:0]  BLANK        = 8'hff;
    localparam logic [15:0] RSV_ENCAP    = 16'hfffe;
    localparam logic [15:0] RSV_OTHER    = 16'hffff;
    // ----------------------------------------------------------------
    // Host register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_STAT     = 8'h01;
    localparam logic [7:0]  REG_TWR      = 8'h02;
    localparam logic [7:0]  REG_SEC0     = 8'h10;
    localparam logic [7:0]  REG_E48_LO   = 8'h20;
    localparam logic [7:0]  REG_E48_HI   = 8'h21;
    localparam logic [7:0]  REG_E64_LO   = 8'h22;
    localparam logic [7:0]  REG_E64_HI   = 8'h23;
    localparam logic [7:0]  REG_E64X_LO  = 8'h24;
    localparam logic [7:0]  REG_E64X_HI  = 8'h25;
    localparam int          ST_BUSY      = 0;
    localparam int          ST_DONE      = 1;
    localparam int          ST_E48_OK    = 2;
    localparam int          ST_E64_OK    = 3;
    localparam int          ST_RSV_ERR   = 4;
    localparam int          ST_WR_REFUSE = 5;
endpackage

// ### rtl/spme_if.sv
// Purpose: Byte-wide table access between host and flash ends
// Assumes: One clock shared by both ends
// Notes:   Read data and write refusal appear one cycle after the strobe
`timescale 1ns/1ns
interface spme_if;
    logic [11:0] tbl_addr;
    logic        tbl_rd;
    logic        tbl_wr;
    logic [7:0]  tbl_wdata;
    logic [7:0]  tbl_rdata;
    logic        tbl_wr_refused;

    modport flash (
        input  tbl_addr,
        input  tbl_rd,
        input  tbl_wr,
        input  tbl_wdata,
        output tbl_rdata,
        output tbl_wr_refused
    );
    modport host (
        output tbl_addr,
        output tbl_rd,
        output tbl_wr,
        output tbl_wdata,
        input  tbl_rdata,
        input  tbl_wr_refused
    );
endinterface

// ### rtl/spme_flash.sv
// Purpose: Flash end serving the vendor table and the protect bit map
// Assumes: Table strobes one cycle long, sampled on core_clk_in
// Notes:   Whole vendor table is read-only; identifiers fixed at build
`timescale 1ns/1ns
module spme_flash #(
    parameter int          M          = spme_pkg::M_DEFAULT,
    // Identifier values below are arbitrary
    parameter logic [47:0] EUI48_VAL  = 48'h02_aa_bb_00_00_01,
    parameter logic [63:0] EUI64_VAL  = 64'h02_aa_bb_01_00_00_00_01,
    parameter bit          EUI48_PROG = 1'b1,
    parameter bit          EUI64_PROG = 1'b1,
    parameter int          AW         = M + spme_pkg::SH_64K
) (
    input  wire logic          core_clk_in,
    input  wire logic          rst_in,
    input  wire logic          ce_in,
    spme_if.flash              tbl,
    input  wire logic [AW-1:0] blk_addr_in,
    output logic      [9:0]    prot_bit_out,
    output logic      [9:0]    prot_rd_bit_out,
    output logic               prot_pair_out
);
    // ----------------------------------------------------------------
    // Section constants
    // ----------------------------------------------------------------
    // density constant sets the base
    // Base grows with density; M outside 4..8 is not guarded
    localparam int BASE = (1 << M) + 1;

    localparam logic [7:0] SEC_TYPE [spme_pkg::SEC_COUNT] = '{
        spme_pkg::TYPE_8K, spme_pkg::TYPE_32K, spme_pkg::TYPE_64K,
        spme_pkg::TYPE_32K, spme_pkg::TYPE_8K};
    localparam logic [7:0] SEC_N [spme_pkg::SEC_COUNT] = '{
        spme_pkg::N_8K, spme_pkg::N_32K, 8'(M), spme_pkg::N_32K, spme_pkg::N_8K};
    localparam logic [7:0] SEC_FIRST [spme_pkg::SEC_COUNT] = '{
        spme_pkg::ADD_B8_FIRST, spme_pkg::ADD_L32, spme_pkg::ADD_64_FIRST,
        spme_pkg::ADD_U32, spme_pkg::ADD_T8_FIRST};
    localparam logic [7:0] SEC_LAST [spme_pkg::SEC_COUNT] = '{
        spme_pkg::ADD_B8_LAST, spme_pkg::ADD_L32, spme_pkg::ADD_64_LAST,
        spme_pkg::ADD_U32, spme_pkg::ADD_T8_LAST};

    // reserved extension prefix withholds the identifier
    localparam bit E64_LEGAL = (EUI64_VAL[39:24] != spme_pkg::RSV_ENCAP) &&
                               (EUI64_VAL[39:24] != spme_pkg::RSV_OTHER);
    localparam bit E64_SHOWN = EUI64_PROG && E64_LEGAL;

    // ----------------------------------------------------------------
    // Adder to bit index
    // ----------------------------------------------------------------
    // zero field is bit 0
    function automatic logic [9:0] bit_of(input logic [7:0] c);
        logic [10:0] sum;
        sum = 11'(BASE) + {{3{c[7]}}, c};
        bit_of = (c == 8'h00) ? 10'h000 : sum[9:0];
    endfunction

    // ----------------------------------------------------------------
    // Table contents
    // ----------------------------------------------------------------
    function automatic logic [7:0] table_byte(input logic [11:0] a);
        logic [11:0] rel;
        logic [2:0]  sec;
        rel        = a - spme_pkg::SEC_BASE;
        sec        = rel[4:2];
        // Unmapped bytes read as erased
        table_byte = spme_pkg::BLANK;
        if (a >= spme_pkg::SEC_BASE && a < spme_pkg::EUI48_FLAG) begin
            unique case (rel[1:0])
                2'd0: table_byte = SEC_TYPE[sec];
                2'd1: table_byte = SEC_N[sec];
                2'd2: table_byte = SEC_FIRST[sec];
                2'd3: table_byte = SEC_LAST[sec];
            endcase
        end else if (a == spme_pkg::EUI48_FLAG) begin
            table_byte = EUI48_PROG ? spme_pkg::EUI48_SET : spme_pkg::BLANK;
        end else if (a >= spme_pkg::EUI48_LO && a <= spme_pkg::EUI48_HI) begin
            // octet 5 lowest, OUI on top
            if (EUI48_PROG) begin
                table_byte = EUI48_VAL[8*(a - spme_pkg::EUI48_LO) +: 8];
            end
        end else if (a == spme_pkg::EUI64_FLAG) begin
            table_byte = E64_SHOWN ? spme_pkg::EUI64_SET : spme_pkg::BLANK;
        end else if (a >= spme_pkg::EUI64_LO && a <= spme_pkg::EUI64_HI) begin
            // octet 7 lowest, 24-bit OUI on top
            if (E64_SHOWN) begin
                table_byte = EUI64_VAL[8*(a - spme_pkg::EUI64_LO) +: 8];
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Table port
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            tbl.tbl_rdata <= 8'h00;
        end else if (ce_in && tbl.tbl_rd) begin
            tbl.tbl_rdata <= table_byte(tbl.tbl_addr);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            tbl.tbl_wr_refused <= 1'b0;
        end else if (ce_in) begin
            tbl.tbl_wr_refused <= tbl.tbl_wr;
        end
    end

    // ----------------------------------------------------------------
    // Block address to protect bit
    // ----------------------------------------------------------------
    logic [M-1:0] top_bits;
    logic [1:0]   sub_8k;
    logic [9:0]   bit_next;
    logic [9:0]   rd_bit_next;
    logic         pair_next;

    assign top_bits = blk_addr_in[AW-1:spme_pkg::SH_64K];
    assign sub_8k   = blk_addr_in[spme_pkg::SH_32K-1:spme_pkg::SH_8K];

    always_comb begin
        bit_next    = 10'h000;
        rd_bit_next = 10'h000;
        pair_next   = 1'b0;
        if (top_bits == '0) begin
            if (blk_addr_in[spme_pkg::SH_32K]) begin
                bit_next    = bit_of(spme_pkg::ADD_L32);
                rd_bit_next = bit_next;
            end else begin
                // even write lock, odd read lock
                bit_next    = bit_of(spme_pkg::ADD_B8_FIRST) + {7'h00, sub_8k, 1'b0};
                rd_bit_next = bit_next + 10'h001;
                pair_next   = 1'b1;
            end
        end else if (top_bits == '1) begin
            if (blk_addr_in[spme_pkg::SH_32K]) begin
                bit_next    = bit_of(spme_pkg::ADD_T8_FIRST) + {7'h00, sub_8k, 1'b0};
                rd_bit_next = bit_next + 10'h001;
                pair_next   = 1'b1;
            end else begin
                bit_next    = bit_of(spme_pkg::ADD_U32);
                rd_bit_next = bit_next;
            end
        end else begin
            bit_next    = bit_of(spme_pkg::ADD_64_FIRST) + 10'(top_bits) - 10'h001;
            rd_bit_next = bit_next;
        end
    end

    // ----------------------------------------------------------------
    // Lookup outputs
    // ----------------------------------------------------------------
    // Registered so the address decode never reaches the pins
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            prot_bit_out <= 10'h000;
        end else if (ce_in) begin
            prot_bit_out <= bit_next;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            prot_rd_bit_out <= 10'h000;
        end else if (ce_in) begin
            prot_rd_bit_out <= rd_bit_next;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            prot_pair_out <= 1'b0;
        end else if (ce_in) begin
            prot_pair_out <= pair_next;
        end
    end
endmodule

// ### testbench/spme_link_checker.sv
// Purpose: Watches the table link between the host and flash ends
// Assumes: ce_in held high; flash built with both identifiers programmed
// Notes:   Expected bytes follow the signed adders for density M
`timescale 1ns/1ns
module spme_link_checker #(
    parameter int M = spme_pkg::M_DEFAULT
) (
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    input wire logic [11:0] tbl_addr,
    input wire logic        tbl_rd,
    input wire logic        tbl_wr,
    input wire logic [7:0]  tbl_rdata,
    input wire logic        tbl_wr_refused
);
    // ------------------------------------------------------------
    // Table contents and write refusal
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    property p_byte(logic [11:0] a, logic [7:0] v);
        tbl_rd && tbl_addr == a |=> tbl_rdata == v;
    endproperty
    a_type_bottom: assert property (p_byte(12'h24c, 8'h02)) else $error("bottom type bad");
    a_count_bottom: assert property (p_byte(12'h24d, 8'h02)) else $error("8k count bad");
    a_bottom_first: assert property (p_byte(12'h24e, 8'hff)) else $error("8k first bad");
    a_bottom_last: assert property (p_byte(12'h24f, 8'h04)) else $error("8k last bad");
    a_lower_span: assert property (tbl_rd && tbl_addr inside {12'h252, 12'h253} |=>
        tbl_rdata == 8'hfd) else $error("lower 32k adder bad");
    a_density_count: assert property (p_byte(12'h255, 8'(M))) else $error("64k count bad");
    a_block_span: assert property (tbl_rd && tbl_addr inside {12'h256, 12'h257} |=>
        tbl_rdata == ($past(tbl_addr[0]) ? 8'hfc : 8'h00)) else $error("64k adders bad");
    a_upper_span: assert property (tbl_rd && tbl_addr inside {12'h25a, 12'h25b} |=>
        tbl_rdata == 8'hfe) else $error("upper 32k adder bad");
    a_top_span: assert property (tbl_rd && tbl_addr inside {12'h25e, 12'h25f} |=>
        tbl_rdata == ($past(tbl_addr[0]) ? 8'h0e : 8'h07)) else $error("top 8k adders bad");
    a_flag_eui48: assert property (p_byte(12'h260, 8'h30)) else $error("48 flag bad");
    a_flag_eui64: assert property (p_byte(12'h267, 8'h40)) else $error("64 flag bad");
    a_write_refused: assert property (tbl_wr |=> tbl_wr_refused) else $error("no refusal");
    a_refuse_cause: assert property (tbl_wr_refused |-> $past(tbl_wr)) else $error("stray refuse");
    a_rdata_holds: assert property (!$past(tbl_rd) |-> $stable(tbl_rdata)) else $error("rdata moved");
    c_walk: cover property (tbl_rd && tbl_addr == 12'h24c);
    c_last_id: cover property (tbl_rd && tbl_addr == 12'h26f);
    c_refuse: cover property (tbl_wr ##1 tbl_wr_refused);
endmodule

// ### testbench/tb_sfdp_protect_map_and_eui.sv
// Purpose: Walks the vendor table through the host and probes the map
// Assumes: Density M=5, ce_in high except for one held-output lookup
// Notes:   Identifier values are arbitrary and use a non-default OUI
`timescale 1ns/1ns
module tb_sfdp_protect_map_and_eui;
    // ------------------------------------------------------------
    // Set-up
    // ------------------------------------------------------------
    localparam logic [47:0] E48 = 48'h0a_1b_2c_3d_4e_5f;
    localparam logic [63:0] E64 = 64'h0a_1b_2c_7e_00_11_22_33;
    logic        core_clk_in, rst_in, ce_in, wr, rd, prot_pair;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, got;
    logic [20:0] blk_addr;
    logic [9:0]  prot_bit, prot_rd_bit;
    int          mismatches, cmp_count, n;
    logic [31:0] sec_exp [5] = '{{4'h2, 8'h04, 10'h025, 10'h020}, {4'h3, 8'h01, 10'h01e, 10'h01e},
        {4'h4, 8'h1e, 10'h01d, 10'h000}, {4'h3, 8'h01, 10'h01f, 10'h01f},
        {4'h2, 8'h04, 10'h02f, 10'h028}};
    spme_if link ();
    spme_flash #(.EUI48_VAL(E48), .EUI64_VAL(E64)) u_spme_flash (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .ce_in(ce_in), .tbl(link.flash), .blk_addr_in(blk_addr),
        .prot_bit_out(prot_bit), .prot_rd_bit_out(prot_rd_bit), .prot_pair_out(prot_pair));
    spme_host u_spme_host (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .tbl(link.host), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata));
    spme_link_checker u_spme_link_checker (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .tbl_addr(link.tbl_addr), .tbl_rd(link.tbl_rd), .tbl_wr(link.tbl_wr),
        .tbl_rdata(link.tbl_rdata), .tbl_wr_refused(link.tbl_wr_refused));
    initial begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk_in);
        wr    <= 1'b0;
    endtask
    // Read data appear in the cycle after the strobe and hold until the next read
    task automatic rd_reg(input logic [7:0] a);
        @(posedge core_clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk_in);
        rd   <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic walk();
        wr_reg(spme_pkg::REG_CTRL, 32'h0000_0001);
        n = 0;
        do begin
            rd_reg(spme_pkg::REG_STAT);
            n++;
        end while (got[1] !== 1'b1 && n < 100);
    endtask
    task automatic look(input int a, input int wb, input int rb, input logic pr);
        @(posedge core_clk_in);
        blk_addr <= 21'(a);
        repeat (2) @(posedge core_clk_in);
        #1 chk("prot_bit", 32'(wb), 32'(prot_bit));
        chk("prot_rd_bit", 32'(rb), 32'(prot_rd_bit));
        chk("prot_pair", 32'(pr), 32'(prot_pair));
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {rst_in, ce_in, wr, rd, addr, wdata, blk_addr} = {2'b11, 2'b00, 8'h00, 32'h0, 21'h0};
        mismatches = 0;
        cmp_count  = 0;
        repeat (20) @(posedge core_clk_in);
        rst_in <= 1'b0;
        rd_reg(spme_pkg::REG_SEC0);
        chk("sec0 before walk", 32'h0, got);
        rd_reg(8'h7f);
        chk("unmapped", 32'h0, got);
        walk();
        chk("stat after walk", 32'h0000_000e, got);
        for (int k = 0; k < 5; k++) begin
            rd_reg(8'(spme_pkg::REG_SEC0 + k));
            chk("section", sec_exp[k], got);
        end
        $display("test sections done");
        rd_reg(spme_pkg::REG_E48_LO);
        chk("eui48 lo", E48[31:0], got);
        rd_reg(spme_pkg::REG_E48_HI);
        chk("eui48 hi", 32'(E48[47:32]), got);
        rd_reg(spme_pkg::REG_E64_LO);
        chk("eui64 lo", E64[31:0], got);
        rd_reg(spme_pkg::REG_E64_HI);
        chk("eui64 hi", E64[63:32], got);
        rd_reg(spme_pkg::REG_E64X_LO);
        chk("encap lo", {8'hfe, E48[23:0]}, got);
        rd_reg(spme_pkg::REG_E64X_HI);
        chk("encap hi", {E48[47:24], 8'hff}, got);
        $display("test identifiers done");
        wr_reg(spme_pkg::REG_TWR, {12'h0, 12'h266, 8'h00});
        repeat (8) @(posedge core_clk_in);
        rd_reg(spme_pkg::REG_STAT);
        chk("stat refused", 32'h0000_0020, got & 32'h0000_0020);
        walk();
        rd_reg(spme_pkg::REG_E48_HI);
        chk("eui48 kept", 32'(E48[47:32]), got);
        $display("test write lock done");
        ce_in <= 1'b1;
        for (int k = 0; k < 4; k++) look(k * 32'h2000, 32 + 2 * k, 33 + 2 * k, 1'b1);
        look(32'h8000, 30, 30, 1'b0);
        for (int j = 1; j < 31; j += 14) look(j * 32'h1_0000, j - 1, j - 1, 1'b0);
        look(32'h1f_0000, 31, 31, 1'b0);
        for (int k = 0; k < 4; k++) look(32'h1f_8000 + k * 32'h2000, 40 + 2 * k, 41 + 2 * k, 1'b1);
        @(posedge core_clk_in);
        ce_in <= 1'b0;
        look(32'h0, 46, 47, 1'b1);
        @(posedge core_clk_in);
        ce_in <= 1'b1;
        look(32'h0, 32, 33, 1'b1);
        $display("test lookup done");
        close_out();
    end
    initial begin
        #2000000;
        mismatches++;
        close_out();
    end
endmodule
